// *** src/output_dependency_cfg.svh ***
`ifndef OUTPUT_DEPENDENCY_CFG_SVH
`define OUTPUT_DEPENDENCY_CFG_SVH

// Register offsets
`define OFS_OUT4_T1_PRIMARY 8'h1D
`define OFS_OUT4_T1_SECONDARY 8'h1E
`define OFS_OUT4_T1_LOGIC 8'h1F
`define OFS_OUT4_T2_PRIMARY 8'h20
`define OFS_OUT4_T2_SECONDARY 8'h21
`define OFS_OUT4_T2_LOGIC 8'h22
`define OFS_OUT4_OUTPUT8 8'h23
`define OFS_OUT5_T1_PRIMARY 8'h24
`define OFS_OUT5_T1_SECONDARY 8'h25
`define OFS_OUT5_T1_LOGIC 8'h26
`define OFS_OUT5_OUTPUT8 8'h2A
`define OFS_MANUAL_RESET 8'h40

// Field positions
`define BIT_OUT4_T1_OUTPUT8 0
`define BIT_OUT4_T2_OUTPUT8 1
`define BIT_OUT5_T1_OUTPUT8 0
`define BIT_OUT4_MANUAL_RESET 3
`define BIT_OUT5_MANUAL_RESET 4

// Reset value of every selection byte
`define SEL_RESET 8'h00
// Unmapped read value
`define READ_UNMAPPED 8'h00

// Smaller variant masks: detector five/six, outputs one/two
`define SMALL_DETECTOR_MASK 8'hCF
`define SMALL_LOGIC_MASK 8'hF3
`define FULL_MASK 8'hFF

`endif

// *** src/output_dependency_pkg.sv ***
`default_nettype none

package output_dependency_pkg;

   // Fault or assertion condition of every selectable source, 1 = fault
   typedef struct packed {
      logic [5:0] primary_fault;
      logic [5:0] secondary_fault;
      logic [1:0] watchdog_fault;
      logic [3:0] general_logic_inputs;
      logic [7:0] prog_output_asserted;
   } source_type;

   // Configuration bytes held by the block
   typedef struct packed {
      logic [7:0] out4_term1_primary_sel;
      logic [7:0] out4_term1_secondary_sel;
      logic [7:0] out4_term1_logic_sel;
      logic [7:0] out4_term2_primary_sel;
      logic [7:0] out4_term2_secondary_sel;
      logic [7:0] out4_term2_logic_sel;
      logic [7:0] out4_output8_sel;
      logic [7:0] out5_term1_primary_sel;
      logic [7:0] out5_term1_secondary_sel;
      logic [7:0] out5_term1_logic_sel;
      logic [7:0] out5_output8_sel;
      logic [7:0] manual_reset_assert_sel;
   } cfg_type;

endpackage

`default_nettype wire

// *** src/output_dependency_matrix.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "output_dependency_cfg.svh"

module output_dependency_matrix #(
   parameter bit SMALL_VARIANT = 1'b0
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_b_in,
   // Register port
   input wire logic [7:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_wr_in,
   output logic [7:0] reg_rdata_out,
   // Source conditions
   input wire output_dependency_pkg::source_type sources_in,
   input wire logic manual_reset_n_in,
   // Output assertion levels, 1 = asserted
   output logic out4_assert_out,
   output logic out5_assert_out
);
   import output_dependency_pkg::*;

   cfg_type cfg_r;
   cfg_type cfg_nxt;
   logic [7:0] rdata_r;
   logic [7:0] rdata_nxt;
   logic out4_r;
   logic out4_nxt;
   logic out5_r;
   logic out5_nxt;
   logic term41;
   logic term42;
   logic term51;
   logic mr_out4;
   logic mr_out5;
   logic [5:0] out4_po_view;
   logic [5:0] out5_po_view;

   // One product term: every selected source must be free of fault
   function automatic logic term_ok(
      input logic [7:0] pri_sel,
      input logic [7:0] sec_sel,
      input logic [7:0] lgc_sel,
      input logic po8_sel,
      input source_type s,
      input logic [5:0] po_view,
      input logic is_small
   );
      logic [7:0] det_mask;
      logic [7:0] lgc_mask;
      logic po8_use;
      logic hit_pri;
      logic hit_sec;
      logic hit_lgc;
      det_mask = is_small ? `SMALL_DETECTOR_MASK : `FULL_MASK;
      lgc_mask = is_small ? `SMALL_LOGIC_MASK : `FULL_MASK;
      po8_use = po8_sel & ~is_small;
      // Zero bits mask the source out entirely
      hit_pri = |(pri_sel & det_mask &
                  {s.watchdog_fault, s.primary_fault});
      hit_sec = |(sec_sel & det_mask &
                  {s.general_logic_inputs[1:0],
                   s.secondary_fault});
      hit_lgc = |(lgc_sel & lgc_mask &
                  {po_view, s.general_logic_inputs[3:2]});
      // Empty selection gives a true term
      term_ok = ~(hit_pri | hit_sec | hit_lgc |
                  (po8_use & s.prog_output_asserted[7]));
   endfunction

   // Other-output views, bit 0 = lowest listed output
   assign out4_po_view = {sources_in.prog_output_asserted[6],
                          sources_in.prog_output_asserted[5],
                          sources_in.prog_output_asserted[4],
                          sources_in.prog_output_asserted[2],
                          sources_in.prog_output_asserted[1],
                          sources_in.prog_output_asserted[0]};
   assign out5_po_view = {sources_in.prog_output_asserted[6],
                          sources_in.prog_output_asserted[5],
                          sources_in.prog_output_asserted[3],
                          sources_in.prog_output_asserted[2],
                          sources_in.prog_output_asserted[1],
                          sources_in.prog_output_asserted[0]};

   // Product terms
   assign term41 = term_ok(cfg_r.out4_term1_primary_sel,
                           cfg_r.out4_term1_secondary_sel,
                           cfg_r.out4_term1_logic_sel,
                           cfg_r.out4_output8_sel[`BIT_OUT4_T1_OUTPUT8],
                           sources_in, out4_po_view,
                           SMALL_VARIANT);
   assign term42 = term_ok(cfg_r.out4_term2_primary_sel,
                           cfg_r.out4_term2_secondary_sel,
                           cfg_r.out4_term2_logic_sel,
                           cfg_r.out4_output8_sel[`BIT_OUT4_T2_OUTPUT8],
                           sources_in, out4_po_view,
                           SMALL_VARIANT);
   assign term51 = term_ok(cfg_r.out5_term1_primary_sel,
                           cfg_r.out5_term1_secondary_sel,
                           cfg_r.out5_term1_logic_sel,
                           cfg_r.out5_output8_sel[`BIT_OUT5_T1_OUTPUT8],
                           sources_in, out5_po_view,
                           SMALL_VARIANT);

   // Manual reset overrides the terms while held low
   assign mr_out4 = cfg_r.manual_reset_assert_sel[`BIT_OUT4_MANUAL_RESET]
                    & ~manual_reset_n_in;
   assign mr_out5 = cfg_r.manual_reset_assert_sel[`BIT_OUT5_MANUAL_RESET]
                    & ~manual_reset_n_in;

   // Output levels, registered to keep glitches off the pins
   always_comb begin
      out4_nxt = mr_out4 | ~(term41 | term42);
      out5_nxt = mr_out5 | ~term51;
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         out4_r <= 1'b0;
         out5_r <= 1'b0;
      end else begin
         out4_r <= out4_nxt;
         out5_r <= out5_nxt;
      end
   end

   // Register writes and read mux; unknown offsets ignore writes
   always_comb begin
      cfg_nxt = cfg_r;
      if (reg_wr_in) begin
         unique case (reg_addr_in)
            `OFS_OUT4_T1_PRIMARY:
               cfg_nxt.out4_term1_primary_sel = reg_wdata_in;
            `OFS_OUT4_T1_SECONDARY:
               cfg_nxt.out4_term1_secondary_sel = reg_wdata_in;
            `OFS_OUT4_T1_LOGIC: cfg_nxt.out4_term1_logic_sel = reg_wdata_in;
            `OFS_OUT4_T2_PRIMARY:
               cfg_nxt.out4_term2_primary_sel = reg_wdata_in;
            `OFS_OUT4_T2_SECONDARY:
               cfg_nxt.out4_term2_secondary_sel = reg_wdata_in;
            `OFS_OUT4_T2_LOGIC: cfg_nxt.out4_term2_logic_sel = reg_wdata_in;
            `OFS_OUT4_OUTPUT8: cfg_nxt.out4_output8_sel = reg_wdata_in;
            `OFS_OUT5_T1_PRIMARY:
               cfg_nxt.out5_term1_primary_sel = reg_wdata_in;
            `OFS_OUT5_T1_SECONDARY:
               cfg_nxt.out5_term1_secondary_sel = reg_wdata_in;
            `OFS_OUT5_T1_LOGIC: cfg_nxt.out5_term1_logic_sel = reg_wdata_in;
            `OFS_OUT5_OUTPUT8: cfg_nxt.out5_output8_sel = reg_wdata_in;
            `OFS_MANUAL_RESET: cfg_nxt.manual_reset_assert_sel = reg_wdata_in;
            default: cfg_nxt = cfg_r;
         endcase
      end
      unique case (reg_addr_in)
         `OFS_OUT4_T1_PRIMARY: rdata_nxt = cfg_r.out4_term1_primary_sel;
         `OFS_OUT4_T1_SECONDARY: rdata_nxt = cfg_r.out4_term1_secondary_sel;
         `OFS_OUT4_T1_LOGIC: rdata_nxt = cfg_r.out4_term1_logic_sel;
         `OFS_OUT4_T2_PRIMARY: rdata_nxt = cfg_r.out4_term2_primary_sel;
         `OFS_OUT4_T2_SECONDARY: rdata_nxt = cfg_r.out4_term2_secondary_sel;
         `OFS_OUT4_T2_LOGIC: rdata_nxt = cfg_r.out4_term2_logic_sel;
         `OFS_OUT4_OUTPUT8: rdata_nxt = cfg_r.out4_output8_sel;
         `OFS_OUT5_T1_PRIMARY: rdata_nxt = cfg_r.out5_term1_primary_sel;
         `OFS_OUT5_T1_SECONDARY: rdata_nxt = cfg_r.out5_term1_secondary_sel;
         `OFS_OUT5_T1_LOGIC: rdata_nxt = cfg_r.out5_term1_logic_sel;
         `OFS_OUT5_OUTPUT8: rdata_nxt = cfg_r.out5_output8_sel;
         `OFS_MANUAL_RESET: rdata_nxt = cfg_r.manual_reset_assert_sel;
         default: rdata_nxt = `READ_UNMAPPED;
      endcase
   end

   // Selection bytes clear at reset so no source is selected
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         cfg_r <= {12{`SEL_RESET}};
         rdata_r <= `READ_UNMAPPED;
      end else begin
         cfg_r <= cfg_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   assign reg_rdata_out = rdata_r;
   assign out4_assert_out = out4_r;
   assign out5_assert_out = out5_r;

   // Checks on the dependency logic
   a_out4_wdog_sel: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      cfg_r.out4_term1_primary_sel[6] && sources_in.watchdog_fault[0]
      |-> !term41) else $error("watchdog one ignored by out4 term1");

   a_out4_gpi_sel: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      cfg_r.out4_term1_secondary_sel[7] &&
      sources_in.general_logic_inputs[1]
      |-> !term41) else $error("input two ignored by out4 term1");

   a_out4_po_sel: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      cfg_r.out4_term1_logic_sel[5] && sources_in.prog_output_asserted[4]
      |-> !term41) else $error("output five ignored by out4 term1");

   a_out4_po8_sel: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      !SMALL_VARIANT && cfg_r.out4_output8_sel[1] &&
      sources_in.prog_output_asserted[7]
      |-> !term42) else $error("output eight ignored by term2");

   a_out4_mr_force: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      cfg_r.manual_reset_assert_sel[3] && !manual_reset_n_in
      |=> out4_assert_out) else $error("manual reset missed out4");

   a_out4_t2_pri: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      cfg_r.out4_term2_primary_sel[0] && sources_in.primary_fault[0]
      |-> !term42) else $error("detector one ignored by term2");

   a_out5_pri_sel: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      cfg_r.out5_term1_primary_sel[7] && sources_in.watchdog_fault[1]
      |-> !term51) else $error("watchdog two ignored by out5");

   a_out5_sec_sel: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      cfg_r.out5_term1_secondary_sel[2] && sources_in.secondary_fault[2]
      |-> !term51) else $error("secondary three ignored by out5");

   a_out5_po_sel: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      cfg_r.out5_term1_logic_sel[4] && sources_in.prog_output_asserted[2]
      |-> !term51) else $error("output three ignored by out5");

   a_out5_mr_force: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      cfg_r.manual_reset_assert_sel[4] && !manual_reset_n_in
      |=> out5_assert_out) else $error("manual reset missed out5");

   a_out4_deassert: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      (term41 || term42) && !mr_out4
      |=> !out4_assert_out) else $error("out4 stays asserted");

   a_out5_level: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      !term51 |=> out5_assert_out) else $error("out5 not asserted");

   a_empty_term: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      cfg_r.out5_term1_primary_sel == 8'h00 &&
      cfg_r.out5_term1_secondary_sel == 8'h00 &&
      cfg_r.out5_term1_logic_sel == 8'h00 &&
      cfg_r.out5_output8_sel[0] == 1'b0
      |-> term51) else $error("empty term not true");

   a_small_ignore: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      SMALL_VARIANT && cfg_r.out5_term1_primary_sel == 8'h30
      && cfg_r.out5_term1_secondary_sel == 8'h00
      && cfg_r.out5_term1_logic_sel == 8'h0C
      && cfg_r.out5_output8_sel[0] == 1'b1
      |-> term51) else $error("unused bits not ignored");

   a_reg_write: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      reg_wr_in && reg_addr_in == `OFS_OUT5_OUTPUT8
      |=> cfg_r.out5_output8_sel == $past(reg_wdata_in))
      else $error("register write lost");

   // Output eight, general inputs and zero selections
   a_out5_po8_sel: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      !SMALL_VARIANT && cfg_r.out5_output8_sel[0] &&
      sources_in.prog_output_asserted[7]
      |-> !term51) else $error("output eight ignored by out5");

   a_out4_t1_po8: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      !SMALL_VARIANT && cfg_r.out4_output8_sel[0] &&
      sources_in.prog_output_asserted[7]
      |-> !term41) else $error("output eight ignored by term1");

   a_out4_lgc_gpi: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      cfg_r.out4_term1_logic_sel[0] && sources_in.general_logic_inputs[2]
      |-> !term41) else $error("input three ignored by out4");

   a_out5_sec_gpi: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      cfg_r.out5_term1_secondary_sel[6] && sources_in.general_logic_inputs[0]
      |-> !term51) else $error("input one ignored by out5");

   // Empty term after reset must not hold output four asserted
   a_out4_empty: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      cfg_r.out4_term1_primary_sel == 8'h00 &&
      cfg_r.out4_term1_secondary_sel == 8'h00 &&
      cfg_r.out4_term1_logic_sel == 8'h00 &&
      cfg_r.out4_output8_sel[0] == 1'b0
      |-> term41) else $error("empty out4 term not true");

   // Unselected manual reset must leave the terms in charge
   a_mr_ignored: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      !cfg_r.manual_reset_assert_sel[3] && term41
      |=> !out4_assert_out) else $error("unselected manual reset");

endmodule

`default_nettype wire

// *** bench/tb_output_dependency_matrix.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "output_dependency_cfg.svh"

module tb_output_dependency_matrix;
   import output_dependency_pkg::*;

   // One expected result, due at a given falling edge
   typedef struct {
      int due;
      logic [7:0] rdata;
      logic [1:0] outs;
      logic [1:0] outs_s;
   } note_type;

   logic clk_in;
   logic rst_b_in;
   logic [7:0] reg_addr_in;
   logic [7:0] reg_wdata_in;
   logic reg_wr_in;
   logic [7:0] reg_rdata_out;
   source_type sources_in;
   logic manual_reset_n_in;
   logic out4_assert_out;
   logic out5_assert_out;
   logic [7:0] small_rdata;
   logic small_out4;
   logic small_out5;
   note_type notes[$];
   note_type cur;
   logic [7:0] mreg [0:255];
   logic [7:0] ofs [0:11];
   int fails = 0;
   int n_checks = 0;
   int ncyc = 0;
   int seed = 62;

   // 250 MHz clock
   initial begin
      clk_in = 1'b0;
      forever #2 clk_in = ~clk_in;
   end

   output_dependency_matrix u_output_dependency_matrix (
      .clk_in(clk_in),
      .rst_b_in(rst_b_in),
      .reg_addr_in(reg_addr_in),
      .reg_wdata_in(reg_wdata_in),
      .reg_wr_in(reg_wr_in),
      .reg_rdata_out(reg_rdata_out),
      .sources_in(sources_in),
      .manual_reset_n_in(manual_reset_n_in),
      .out4_assert_out(out4_assert_out),
      .out5_assert_out(out5_assert_out)
   );

   // Smaller variant on the same stimulus; its unused bits are ignored
   output_dependency_matrix #(
      .SMALL_VARIANT(1'b1)
   ) u_output_dependency_matrix_small (
      .clk_in(clk_in),
      .rst_b_in(rst_b_in),
      .reg_addr_in(reg_addr_in),
      .reg_wdata_in(reg_wdata_in),
      .reg_wr_in(reg_wr_in),
      .reg_rdata_out(small_rdata),
      .sources_in(sources_in),
      .manual_reset_n_in(manual_reset_n_in),
      .out4_assert_out(small_out4),
      .out5_assert_out(small_out5)
   );

   // Term true when no selected source is in fault, empty term true
   function automatic logic term(input logic [7:0] p, s, l,
                                 input logic o8, input logic [5:0] pv,
                                 input source_type x);
      logic f;
      f = |(p & {x.watchdog_fault, x.primary_fault});
      f = f | |(s & {x.general_logic_inputs[1:0],
                     x.secondary_fault});
      f = f | |(l & {pv, x.general_logic_inputs[3:2]});
      f = f | (o8 & x.prog_output_asserted[7]);
      return !f;
   endfunction

   function automatic logic mapped(input logic [7:0] a);
      mapped = 1'b0;
      for (int i = 0; i < 12; i++) begin
         if (ofs[i] == a) mapped = 1'b1;
      end
   endfunction

   // Drive one cycle and note what shows two falling edges later
   task automatic step(input logic [7:0] a, d, input logic w,
                       input source_type s, input logic mrn);
      note_type n;
      logic [5:0] p4, p5;
      logic t41, t42, t51, m4, m5;
      logic t41s, t42s, t51s;
      @(posedge clk_in);
      reg_addr_in <= a;
      reg_wdata_in <= d;
      reg_wr_in <= w;
      sources_in <= s;
      manual_reset_n_in <= mrn;
      p4 = {s.prog_output_asserted[6:4], s.prog_output_asserted[2:0]};
      p5 = {s.prog_output_asserted[6:5], s.prog_output_asserted[3:0]};
      t41 = term(mreg[8'h1D], mreg[8'h1E], mreg[8'h1F], mreg[8'h23][0],
                 p4, s);
      t42 = term(mreg[8'h20], mreg[8'h21], mreg[8'h22], mreg[8'h23][1],
                 p4, s);
      t51 = term(mreg[8'h24], mreg[8'h25], mreg[8'h26], mreg[8'h2A][0],
                 p5, s);
      m4 = mreg[8'h40][3] & !mrn;
      m5 = mreg[8'h40][4] & !mrn;
      // Small model sees the bits a careful host leaves at zero
      t41s = term(mreg[8'h1D] & `SMALL_DETECTOR_MASK,
                  mreg[8'h1E] & `SMALL_DETECTOR_MASK,
                  mreg[8'h1F] & `SMALL_LOGIC_MASK, 1'b0, p4, s);
      t42s = term(mreg[8'h20] & `SMALL_DETECTOR_MASK,
                  mreg[8'h21] & `SMALL_DETECTOR_MASK,
                  mreg[8'h22] & `SMALL_LOGIC_MASK, 1'b0, p4, s);
      t51s = term(mreg[8'h24] & `SMALL_DETECTOR_MASK,
                  mreg[8'h25] & `SMALL_DETECTOR_MASK,
                  mreg[8'h26] & `SMALL_LOGIC_MASK, 1'b0, p5, s);
      n.due = ncyc + 2;
      n.rdata = mreg[a];
      n.outs = {m5 | !t51, m4 | !(t41 | t42)};
      n.outs_s = {m5 | !t51s, m4 | !(t41s | t42s)};
      notes.push_back(n);
      // Unmapped writes leave the model untouched
      if (w && mapped(a)) mreg[a] = d;
   endtask

   // Reset after the queue has drained, so no note straddles it
   task automatic do_reset();
      note_type n;
      repeat (2) @(posedge clk_in);
      rst_b_in <= 1'b0;
      reg_wr_in <= 1'b0;
      n.due = ncyc + 1;
      n.rdata = 8'h00;
      n.outs = 2'b00;
      n.outs_s = 2'b00;
      notes.push_back(n);
      for (int i = 0; i < 256; i++) mreg[i] = 8'h00;
      repeat (5) @(posedge clk_in);
      rst_b_in <= 1'b1;
   endtask

   // Every mapped byte plus two unmapped places
   task automatic read_all();
      for (int i = 0; i < 12; i++) step(ofs[i], 8'hFF, 1'b0, '0, 1'b1);
      step(8'h27, 8'h5A, 1'b1, '0, 1'b1);
      step(8'h27, 8'h00, 1'b0, '0, 1'b1);
      step(8'hFF, 8'h00, 1'b0, '0, 1'b1);
   endtask

   // Monitor: oldest note against the settled outputs
   always @(negedge clk_in) begin
      ncyc++;
      while (notes.size() > 0 && notes[0].due <= ncyc) begin
         cur = notes.pop_front();
         n_checks++;
         if (reg_rdata_out !== cur.rdata) begin
            fails++;
            $display("CHECK FAILED t=%0t read %h exp %h", $time,
                     reg_rdata_out, cur.rdata);
         end
         n_checks++;
         if ({out5_assert_out, out4_assert_out} !== cur.outs) begin
            fails++;
            $display("CHECK FAILED t=%0t outs %b exp %b", $time,
                     {out5_assert_out, out4_assert_out}, cur.outs);
         end
         n_checks++;
         if ({small_out5, small_out4} !== cur.outs_s) begin
            fails++;
            $display("CHECK FAILED t=%0t small outs %b exp %b", $time,
                     {small_out5, small_out4}, cur.outs_s);
         end
         n_checks++;
         if (small_rdata !== cur.rdata) begin
            fails++;
            $display("CHECK FAILED t=%0t small read %h exp %h", $time,
                     small_rdata, cur.rdata);
         end
      end
   end

   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // Watchdog, well past the expected 12.3 us of traffic
   initial begin
      #60000;
      fails++;
      $display("CHECK FAILED t=%0t watchdog expired", $time);
      complete_run();
   end

   initial begin
      logic [31:0] r;
      logic [7:0] a;
      logic [7:0] mr_sel [0:2];
      ofs = '{8'h1D, 8'h1E, 8'h1F, 8'h20, 8'h21, 8'h22, 8'h23, 8'h24,
              8'h25, 8'h26, 8'h2A, 8'h40};
      mr_sel = '{8'h08, 8'h10, 8'h18};
      rst_b_in = 1'b0;
      reg_addr_in = 8'h00;
      reg_wdata_in = 8'h00;
      reg_wr_in = 1'b0;
      sources_in = '0;
      manual_reset_n_in = 1'b1;
      do_reset();
      read_all();
      $display("test reset values done");
      // Sparse random traffic keeps terms near an even mix
      repeat (3000) begin
         r = $random(seed);
         a = r[0] ? ofs[$unsigned($random(seed)) % 12] : r[15:8];
         r = $random(seed) & $random(seed) & $random(seed);
         step(a, r[7:0], r[16], r[25:0], r[20]);
      end
      $display("test random traffic done");
      // Manual reset alone, with every term empty
      do_reset();
      for (int i = 0; i < 3; i++) begin
         step(8'h40, mr_sel[i], 1'b1, '0, 1'b1);
         step(8'h40, 8'h00, 1'b0, '0, 1'b0);
         step(8'h40, 8'h00, 1'b0, '0, 1'b1);
      end
      $display("test manual reset done");
      // Out5 term one selects only bits the smaller variant lacks
      step(8'h24, 8'h30, 1'b1, '0, 1'b1);
      step(8'h25, 8'h00, 1'b1, '0, 1'b1);
      step(8'h26, 8'h0C, 1'b1, '0, 1'b1);
      step(8'h2A, 8'h01, 1'b1, '0, 1'b1);
      repeat (8) begin
         r = $random(seed);
         r[7] = 1'b1;
         step(8'h2A, 8'h00, 1'b0, r[25:0], 1'b1);
      end
      $display("test small variant done");
      // Mid-run reset must clear every byte
      do_reset();
      read_all();
      $display("test second reset done");
      repeat (4) @(posedge clk_in);
      complete_run();
   end

endmodule

`default_nettype wire
